// *** verilog/sac_pkg.sv ***
// constants and types for the conversion sequencer
`default_nettype none
package sac_pkg;

	// bus clock rate
	localparam int unsigned SAC_CLK_HZ = 20_000_000;

	// register byte offsets
	localparam logic [7:0] SAC_OFS_STATUS = 8'h00;
	localparam logic [7:0] SAC_OFS_CLOCK  = 8'h04;
	localparam logic [7:0] SAC_OFS_RES_HI = 8'h08;
	localparam logic [7:0] SAC_OFS_RES_LO = 8'h0C;

	// status/control field positions
	localparam int SAC_ST_CH_LSB = 0;
	localparam int SAC_ST_CONT   = 5;
	localparam int SAC_ST_IRQEN  = 6;
	localparam int SAC_ST_DONE   = 7;

	// clock configuration field positions
	localparam int SAC_CK_SEL     = 0;
	localparam int SAC_CK_TEN     = 1;
	localparam int SAC_CK_LONG    = 2;
	localparam int SAC_CK_DIV_LSB = 3;
	localparam int SAC_CK_ASYNC   = 5;
	localparam int SAC_CK_HW      = 6;

	// reset values
	localparam logic [4:0] SAC_CH_OFF      = 5'h1F;
	localparam logic [7:0] SAC_CLOCK_RST   = 8'h00;

	// conversion lengths in converter clocks
	localparam logic [5:0] SAC_FIRST_8S = 6'd18;
	localparam logic [5:0] SAC_FIRST_8L = 6'd38;
	localparam logic [5:0] SAC_FIRST_AS = 6'd21;
	localparam logic [5:0] SAC_FIRST_AL = 6'd41;
	localparam logic [5:0] SAC_NEXT_8S  = 6'd16;
	localparam logic [5:0] SAC_NEXT_8L  = 6'd36;
	localparam logic [5:0] SAC_NEXT_AS  = 6'd19;
	localparam logic [5:0] SAC_NEXT_AL  = 6'd39;

	// bus clocks of start synchronisation
	localparam logic [1:0] SAC_SYNC_BUS = 2'd3;

	// sample window in half converter clocks (3.5 and 23.5)
	localparam logic [6:0] SAC_SAMPLE_SHORT_HALF = 7'd7;
	localparam logic [6:0] SAC_SAMPLE_LONG_HALF  = 7'd47;

	// alternate source edges per bus clock
	localparam logic [2:0] SAC_ALT_EDGES = 3'd4;

	typedef enum logic [1:0] {SAC_IDLE, SAC_SYNC, SAC_CONV} sac_phase_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} sac_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} sac_wb_rsp_t;

	typedef struct packed {
		sac_phase_t  phase;
		logic [4:0]  channel;
		logic        cont;
		logic        irq_en;
		logic        done;
		logic        irq;
		logic        clk_sel;
		logic        ten_bit;
		logic        long_smp;
		logic [1:0]  div;
		logic        async_en;
		logic        hw_sel;
		logic [1:0]  res_hi;
		logic [7:0]  res_lo;
		logic        hi_read;
		logic        first;
		logic [1:0]  sync_left;
		logic [5:0]  converter_clock_left;
		logic [3:0]  div_acc;
		logic [2:0]  trig;
		logic [2:0]  aclk;
		logic        ack;
		logic [7:0]  rdata;
	} sac_state_t;

endpackage : sac_pkg
`default_nettype wire

// *** verilog/sac_conv_ctrl.sv ***
// conversion sequencer of the 10-bit successive-approximation converter
// Contract
// - results in 10-bit or 8-bit resolution
// - software mode starts on status write
// - hardware mode starts on trigger event
// - continuous mode restarts after result transfer
// - continuous runs from first start until abort
// - completion loads results and sets done
// - interrupt raised if enabled at setting
// - high read pending blocks new result
// - blocked transfer starts another conversion unless aborted in the same cycle
// - status write aborts, restarts unless channel off or hardware mode selected
// - clock configuration write aborts conversion
// - stop without async clock aborts
// - abort keeps last completed results
// - reset returns results to reset values
// - abort or reset powers down immediately
// - 8-bit short: 18 first, 16 next
// - 8-bit long: 38 first, 36 next
// - 10-bit short: 21 first, 19 next
// - 10-bit long: 41 first, 39 next
// - async clock may add five microseconds
// - converter clock from selected divided source
// - sample window 3.5 or 23.5 clocks
// - divider by 1, 2, 4 or 8
// - both bits low picks alternate source
// - select high picks bus clock unless async clock enabled
// - done sets regardless of interrupt enable
`timescale 1ns/1ps
`default_nettype none
module sac_conv_ctrl (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 clk_en,
	// register bus
	input  wire sac_pkg::sac_wb_req_t wb_req,
	output var  sac_pkg::sac_wb_rsp_t wb_rsp,
	// converter side
	input  wire logic [9:0]           sar_code,
	input  wire logic                 hw_trigger_pin,
	input  wire logic                 async_clock_pin,
	input  wire logic                 stop_mode,
	output logic                      conv_powered,
	output logic                      sampling,
	output logic [4:0]                channel_sel,
	output logic                      irq_req
);
	import sac_pkg::*;

	// source edges per bus clock
	function automatic logic [2:0] sac_src_edges(
		input logic clk_sel,
		input logic async_en,
		input logic aclk_rise
	);
		logic [2:0] e;
		if (async_en) begin
			e = {2'b00, aclk_rise};
		end else if (clk_sel) begin
			e = 3'd1;
		end else begin
			e = SAC_ALT_EDGES;
		end
		return e;
	endfunction : sac_src_edges

	// conversion length per mode
	function automatic logic [5:0] sac_len(
		input logic ten_bit,
		input logic long_smp,
		input logic first
	);
		logic [5:0] l;
		unique case ({ten_bit, long_smp, first})
			3'b001:  l = SAC_FIRST_8S;
			3'b011:  l = SAC_FIRST_8L;
			3'b101:  l = SAC_FIRST_AS;
			3'b111:  l = SAC_FIRST_AL;
			3'b000:  l = SAC_NEXT_8S;
			3'b010:  l = SAC_NEXT_8L;
			3'b100:  l = SAC_NEXT_AS;
			default: l = SAC_NEXT_AL;
		endcase
		return l;
	endfunction : sac_len

	// round 10-bit code to 8 bits, saturating
	function automatic logic [7:0] sac_round8(input logic [9:0] c);
		logic [10:0] r;
		r = {1'b0, c} + 11'd2;
		return r[10] ? 8'hFF : r[9:2];
	endfunction : sac_round8

	// begin a conversion with start synchronisation
	function automatic sac_state_t sac_start(input sac_state_t x);
		sac_state_t y;
		y = x;
		y.phase = SAC_SYNC;
		y.sync_left = SAC_SYNC_BUS;
		y.first = 1'b1;
		y.div_acc = '0;
		return y;
	endfunction : sac_start

	sac_state_t  s;
	sac_state_t  n;
	logic        req;
	logic        access;
	logic        wr_status;
	logic        wr_clock;
	logic        rd_hi;
	logic        rd_lo;
	logic        stop_abort;
	logic        abort_now;
	logic        trig_rise;
	logic        aclk_rise;
	logic [3:0]  tot;
	logic [3:0]  converter_clock;
	logic        complete;
	logic        blocked;
	logic        done_set;
	logic [5:0]  cur_len;
	logic [6:0]  elapsed_half;
	logic [7:0]  wbyte;
	logic [7:0]  rd_mux;

	// bus decode; effects land on the acknowledged edge
	assign req    = wb_req.cyc && wb_req.stb;
	assign access = req && s.ack;
	assign wbyte  = wb_req.dat[7:0];
	assign wr_status = access && wb_req.we && wb_req.sel[0]
		&& (wb_req.adr == SAC_OFS_STATUS);
	assign wr_clock  = access && wb_req.we && wb_req.sel[0]
		&& (wb_req.adr == SAC_OFS_CLOCK);
	assign rd_hi = access && !wb_req.we
		&& (wb_req.adr == SAC_OFS_RES_HI);
	assign rd_lo = access && !wb_req.we
		&& (wb_req.adr == SAC_OFS_RES_LO);

	assign stop_abort = stop_mode && !s.async_en;
	assign abort_now  = wr_status || wr_clock || stop_abort;

	// synchronised pin edges
	assign trig_rise = s.trig[1] && !s.trig[2];
	assign aclk_rise = s.aclk[1] && !s.aclk[2];

	assign cur_len = sac_len(s.ten_bit, s.long_smp, s.first);
	assign elapsed_half = {cur_len - s.converter_clock_left, 1'b0};

	always_comb begin
		unique case (wb_req.adr)
			SAC_OFS_STATUS: rd_mux = {s.done, s.irq_en, s.cont, s.channel};
			SAC_OFS_CLOCK:  rd_mux = {1'b0, s.hw_sel, s.async_en, s.div,
				s.long_smp, s.ten_bit, s.clk_sel};
			SAC_OFS_RES_HI: rd_mux = {6'h00, s.res_hi};
			SAC_OFS_RES_LO: rd_mux = s.res_lo;
			default:        rd_mux = 8'h00;
		endcase
	end

	always_comb begin
		n = s;
		complete = 1'b0;
		blocked = 1'b0;
		done_set = 1'b0;
		n.ack = req && !s.ack;
		n.trig = {s.trig[1:0], hw_trigger_pin};
		n.aclk = {s.aclk[1:0], async_clock_pin};
		if (n.ack) begin
			n.rdata = rd_mux;
		end
		tot = s.div_acc + {1'b0, sac_src_edges(s.clk_sel, s.async_en,
			aclk_rise)};
		// divide by 1, 2, 4 or 8
		converter_clock = tot >> s.div;
		n.div_acc = tot & ~(4'hF << s.div);
		unique case (s.phase)
			SAC_IDLE: begin
				n.div_acc = '0;
			end
			SAC_SYNC: begin
				if (s.sync_left == 2'd1) begin
					n.phase = SAC_CONV;
					n.converter_clock_left = sac_len(s.ten_bit, s.long_smp, 1'b1);
				end else begin
					n.sync_left = s.sync_left - 2'd1;
				end
			end
			SAC_CONV: begin
				if (s.converter_clock_left <= {2'b00, converter_clock}) begin
					complete = 1'b1;
				end else begin
					n.converter_clock_left = s.converter_clock_left - {2'b00, converter_clock};
				end
			end
		endcase
		if (complete) begin
			// block while high byte read pending
			blocked = s.hi_read;
			if (blocked) begin
				n = sac_start(n);
			end else begin
				done_set = 1'b1;
				n.res_hi = s.ten_bit ? sar_code[9:8] : 2'b00;
				n.res_lo = s.ten_bit ? sar_code[7:0] : sac_round8(sar_code);
				n.done = 1'b1;
				if (s.irq_en) begin
					n.irq = 1'b1;
				end
				if (s.cont) begin
					n.phase = SAC_CONV;
					n.first = 1'b0;
					n.converter_clock_left = sac_len(s.ten_bit, s.long_smp, 1'b0);
				end else begin
					n.phase = SAC_IDLE;
				end
			end
		end
		if (s.hw_sel && trig_rise && s.channel != SAC_CH_OFF
			&& s.phase == SAC_IDLE) begin
			n = sac_start(n);
		end
		if (wr_clock) begin
			n.clk_sel = wbyte[SAC_CK_SEL];
			n.ten_bit = wbyte[SAC_CK_TEN];
			n.long_smp = wbyte[SAC_CK_LONG];
			n.div = wbyte[SAC_CK_DIV_LSB+:2];
			n.async_en = wbyte[SAC_CK_ASYNC];
			n.hw_sel = wbyte[SAC_CK_HW];
			n.phase = SAC_IDLE;
		end
		if (wr_status) begin
			n.channel = wbyte[SAC_ST_CH_LSB+:5];
			n.cont = wbyte[SAC_ST_CONT];
			n.irq_en = wbyte[SAC_ST_IRQEN];
			// write clears done, a set wins
			n.done = done_set;
			n.irq = done_set && s.irq_en;
			if (wbyte[SAC_ST_CH_LSB+:5] != SAC_CH_OFF && !s.hw_sel) begin
				n = sac_start(n);
			end else begin
				n.phase = SAC_IDLE;
			end
		end
		if (stop_abort) begin
			n.phase = SAC_IDLE;
		end
		// low read releases, high read in 10-bit mode arms
		if (rd_lo) begin
			n.hi_read = 1'b0;
		end else if (rd_hi && s.ten_bit) begin
			n.hi_read = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.channel <= SAC_CH_OFF;
		end else if (clk_en) begin
			s <= n;
		end
	end

	// power drops with the abort itself
	assign conv_powered = (s.phase != SAC_IDLE) && !abort_now;
	assign sampling = conv_powered && (s.phase == SAC_CONV)
		&& (elapsed_half < (s.long_smp ? SAC_SAMPLE_LONG_HALF
		: SAC_SAMPLE_SHORT_HALF));
	assign channel_sel = s.channel;
	assign irq_req = s.irq;
	assign wb_rsp.ack = s.ack;
	assign wb_rsp.dat = {24'h000000, s.rdata};

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_sw_start: assert property (clk_en && wr_status && !s.hw_sel && !stop_abort
		&& wbyte[4:0] != SAC_CH_OFF |=> s.phase == SAC_SYNC)
		else $error("software start not taken");

	a_clock_abort: assert property (clk_en && wr_clock |=>
		s.phase == SAC_IDLE)
		else $error("clock write did not abort");

	a_stop_abort: assert property (clk_en && stop_abort |=>
		s.phase == SAC_IDLE && !conv_powered)
		else $error("stop did not abort");

	a_done_set: assert property (clk_en && complete && !blocked |=>
		s.done && s.res_lo == $past(n.res_lo))
		else $error("done flag not set on completion");

	a_block_keep: assert property (clk_en && complete && blocked |=>
		$stable(s.res_lo) && $stable(s.res_hi)
		&& s.done == ($past(s.done) && !$past(wr_status)))
		else $error("blocked result was loaded");

	a_block_restart: assert property (clk_en && complete && blocked
		&& !abort_now ##1 (clk_en && !abort_now) [*3] |=> s.phase == SAC_CONV
		&& s.converter_clock_left == sac_len(s.ten_bit, s.long_smp, 1'b1))
		else $error("no restart after blocked transfer");

	a_irq_gate: assert property (clk_en && complete && !blocked
		&& !wr_status |=> irq_req == $past(s.irq_en) || $past(s.irq))
		else $error("interrupt request wrong at completion");

	a_power_off: assert property (s.phase == SAC_IDLE || abort_now
		|-> !conv_powered && !sampling)
		else $error("converter powered while inactive");

endmodule : sac_conv_ctrl
`default_nettype wire

// *** tb/sac_cpu_model.sv ***
// bus master model of the cpu side
`timescale 1ns/1ps
`default_nettype none
module sac_cpu_model (
	// clock
	input  wire logic                 clock,
	// register bus
	output var  sac_pkg::sac_wb_req_t wb_req,
	input  wire sac_pkg::sac_wb_rsp_t wb_rsp
);
	import sac_pkg::*;
	initial wb_req = '0;
	task automatic access(input logic we, input logic [7:0] adr, wd,
		output logic [7:0] rd, output bit tmo);
		int n;
		n = 0;
		@(posedge clock);
		wb_req <= '{1'b1, 1'b1, we, 4'hF, adr, {24'h0, wd}};
		do begin
			@(posedge clock);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 60);
		tmo = (n >= 60);
		rd = wb_rsp.dat[7:0];
		// released lines show a changed pattern
		wb_req <= '{1'b0, 1'b0, ~we, 4'h0, ~adr, ~{24'h0, wd}};
	endtask : access
endmodule : sac_cpu_model
`default_nettype wire

// *** tb/sac_conv_ctrl_test.sv ***
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sac_conv_ctrl_test;
	import sac_pkg::*;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        stop_mode = 1'b0;
	logic        hw_trigger_pin = 1'b0;
	logic [9:0]  sar_code = 10'h2A5;
	sac_wb_req_t wb_req;
	sac_wb_rsp_t wb_rsp;
	logic        conv_powered;
	logic        sampling;
	logic [4:0]  channel_sel;
	logic        irq_req;
	int          err_total = 0;
	int          cmp_count = 0;

	always #25 clock = ~clock;

	sac_conv_ctrl i_sac_conv_ctrl (.clock(clock), .rst_n(rst_n),
		.clk_en(1'b1), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.sar_code(sar_code), .hw_trigger_pin(hw_trigger_pin),
		.async_clock_pin(1'b0), .stop_mode(stop_mode),
		.conv_powered(conv_powered), .sampling(sampling),
		.channel_sel(channel_sel), .irq_req(irq_req));
	sac_cpu_model i_cpu (.clock(clock), .wb_req(wb_req), .wb_rsp(wb_rsp));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input string what, input logic [7:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic hang();
		err_total++;
		print_verdict();
	endtask : hang
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] r;
		bit         t;
		i_cpu.access(1'b1, a, d, r, t);
		if (t) hang();
	endtask : wr
	task automatic rdc(input string what, input logic [7:0] a, exp);
		logic [7:0] r;
		bit         t;
		i_cpu.access(1'b0, a, 8'h00, r, t);
		if (t) hang();
		check(what, r, exp);
	endtask : rdc
	task automatic wait_irq(output int n);
		n = 0;
		do begin
			@(posedge clock);
			n++;
			if (n > 200) hang();
		end while (irq_req !== 1'b1);
	endtask : wait_irq
	task automatic idle(input int k);
		repeat (k) @(posedge clock);
	endtask : idle

	task automatic reset_values();
		check("channel_sel", {3'h0, channel_sel}, 8'h1F);
		rdc("status", SAC_OFS_STATUS, 8'h1F);
		rdc("clock cfg", SAC_OFS_CLOCK, 8'h00);
		rdc("result high", SAC_OFS_RES_HI, 8'h00);
		rdc("result low", SAC_OFS_RES_LO, 8'h00);
		wr(8'h10, 8'h55);
		rdc("unmapped", 8'h10, 8'h00);
	endtask : reset_values

	task automatic mode_timing();
		logic [7:0] cfg [7] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h19, 8'h00};
		int         lo [7] = '{18, 21, 38, 41, 36, 144, 5};
		int         n;
		for (int i = 0; i < 7; i++) begin
			wr(SAC_OFS_CLOCK, cfg[i]);
			wr(SAC_OFS_STATUS, 8'h40);
			wait_irq(n);
			check("time", 8'(n >= lo[i] && n <= lo[i] + 5), 8'h01);
			rdc("done", SAC_OFS_STATUS, 8'hC0);
			rdc("hi", SAC_OFS_RES_HI, cfg[i][1] ? 8'h02 : 8'h00);
			rdc("lo", SAC_OFS_RES_LO, cfg[i][1] ? 8'hA5 : 8'hA9);
		end
	endtask : mode_timing

	task automatic continuous();
		int n;
		wr(SAC_OFS_CLOCK, 8'h01);
		wr(SAC_OFS_STATUS, 8'h60);
		wait_irq(n);
		sar_code <= 10'h0F0;
		idle(19);
		rdc("next result", SAC_OFS_RES_LO, 8'h3C);
		sar_code <= 10'h3FF;
		check("still on", {7'h0, conv_powered}, 8'h01);
		wr(SAC_OFS_CLOCK, 8'h01);
		#1 check("off", {7'h0, conv_powered}, 8'h00);
		idle(60);
		rdc("kept", SAC_OFS_RES_LO, 8'h3C);
	endtask : continuous

	task automatic blocking();
		int n;
		sar_code <= 10'h155;
		wr(SAC_OFS_CLOCK, 8'h03);
		wr(SAC_OFS_STATUS, 8'h40);
		wait_irq(n);
		rdc("hi first", SAC_OFS_RES_HI, 8'h01);
		sar_code <= 10'h2A5;
		wr(SAC_OFS_STATUS, 8'h40);
		idle(60);
		check("blocked irq", {7'h0, irq_req}, 8'h00);
		check("restarted", {7'h0, conv_powered}, 8'h01);
		rdc("old lo", SAC_OFS_RES_LO, 8'h55);
		wait_irq(n);
		rdc("new hi", SAC_OFS_RES_HI, 8'h02);
		rdc("new lo", SAC_OFS_RES_LO, 8'hA5);
	endtask : blocking

	task automatic aborts();
		wr(SAC_OFS_CLOCK, 8'h01);
		wr(SAC_OFS_STATUS, 8'h00);
		idle(4);
		wr(SAC_OFS_STATUS, 8'h1F);
		#1 check("ch off", {7'h0, conv_powered}, 8'h00);
		wr(SAC_OFS_STATUS, 8'h00);
		idle(4);
		stop_mode <= 1'b1;
		@(posedge clock);
		#1 check("stop", {7'h0, conv_powered}, 8'h00);
		idle(40);
		stop_mode <= 1'b0;
		rdc("no done", SAC_OFS_STATUS, 8'h00);
		rdc("lo kept", SAC_OFS_RES_LO, 8'hA5);
	endtask : aborts

	task automatic hw_start();
		int n;
		wr(SAC_OFS_CLOCK, 8'h41);
		wr(SAC_OFS_STATUS, 8'h40);
		idle(30);
		check("no sw start", {7'h0, irq_req}, 8'h00);
		hw_trigger_pin <= 1'b1;
		wait_irq(n);
		hw_trigger_pin <= 1'b0;
		check("hw time", 8'(n >= 18 && n <= 26), 8'h01);
	endtask : hw_start

	task automatic window_flag();
		int k;
		wr(SAC_OFS_CLOCK, 8'h01);
		wr(SAC_OFS_STATUS, 8'h00);
		k = 0;
		repeat (40) begin
			@(posedge clock);
			if (sampling === 1'b1) k++;
		end
		check("short window", 8'(k), 8'h04);
		check("no irq", {7'h0, irq_req}, 8'h00);
		rdc("done no irq", SAC_OFS_STATUS, 8'h80);
		wr(SAC_OFS_CLOCK, 8'h05);
		wr(SAC_OFS_STATUS, 8'h00);
		k = 0;
		repeat (60) begin
			@(posedge clock);
			if (sampling === 1'b1) k++;
		end
		check("long window", 8'(k), 8'h18);
		wr(SAC_OFS_CLOCK, 8'h20);
		wr(SAC_OFS_STATUS, 8'h00);
		stop_mode <= 1'b1;
		idle(3);
		check("async stop", {7'h0, conv_powered}, 8'h01);
		stop_mode <= 1'b0;
		wr(SAC_OFS_CLOCK, 8'h01);
	endtask : window_flag

	task automatic mid_reset();
		rst_n <= 1'b0;
		idle(2);
		rst_n <= 1'b1;
		rdc("lo after reset", SAC_OFS_RES_LO, 8'h00);
	endtask : mid_reset

	initial begin
		idle(12);
		rst_n <= 1'b1;
		reset_values();
		mode_timing();
		continuous();
		blocking();
		aborts();
		hw_start();
		window_flag();
		mid_reset();
		print_verdict();
	end
endmodule : sac_conv_ctrl_test
`default_nettype wire
